// ===== shared/cts_cfg.svh
/*
   Constants for the current-transformer circuit supervision block:
   sample widths, fixed-point format of the slope factor and reset values.
   Assumes it is included by the package and the design files by bare name.
*/
//
// Behaviour
// - Flag a measuring-circuit failure when the residual derived from the phases disagrees with the measured earth current beyond the limit.
// - Form the residual as the vector sum of the three phases (three times the zero-sequence current) plus the ratio-corrected earth current.
// - Derive the ratio correction from the rated primary and secondary values of phase and earth transformers, with no own setting.
// - Compute the limit as the base deviation plus the slope factor times the largest phase current.
// - Declare an error when the corrected residual magnitude is greater than or equal to the limit.
// - Let the limit grow linearly with the largest phase current to cover current-proportional ratio errors.
// - Raise the supervision alarm on a detected failure so that it can be reported as a message.
// - With a base deviation of 0.1 rated current and a balanced nominal feed, losing one phase raises the alarm.
// - With balanced nominal phases, an earth current above the limit raises the alarm.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// Sample and setting widths
`define CTS_CUR_W     16
`define CTS_RATED_W   12
`define CTS_SLOPE_W   8
// Slope factor is unsigned with this many fraction bits
`define CTS_SLOPE_FRAC 8
// Width of rated products and scaled quantities
`define CTS_PROD_W    24
`define CTS_RES_W     43
`define CTS_LIM_W     41
// Reset values
`define CTS_ALARM_RST 1'b0
`define CTS_VALID_RST 1'b0
// Pipeline latency from sample strobe to alarm update, in clock cycles
`define CTS_LATENCY   3

`endif

// ===== shared/cts_pkg.sv
/*
   Types of the current-transformer circuit supervision block.
   Assumes the constants header is on the include path.
*/
`default_nettype none
`include "cts_cfg.svh"

package cts_pkg;

   typedef logic signed [`CTS_CUR_W-1:0]   cur_t;
   typedef logic        [`CTS_CUR_W-1:0]   mag_t;
   typedef logic        [`CTS_RATED_W-1:0] rated_t;
   typedef logic        [`CTS_SLOPE_W-1:0] slope_t;
   typedef logic        [`CTS_PROD_W-1:0]  prod_t;
   typedef logic signed [`CTS_RES_W-1:0]   res_t;
   typedef logic        [`CTS_RES_W-1:0]   resmag_t;
   typedef logic        [`CTS_LIM_W-1:0]   lim_t;

   // Whole register state of the supervision pipeline
   typedef struct packed {
      logic    v1;
      res_t    res_re;
      res_t    res_im;
      mag_t    imax;
      prod_t   phase_scale;
      logic    v2;
      resmag_t res_mag;
      lim_t    lim;
      logic    alarm;
      logic    alarm_evt;
      resmag_t mag_out;
      lim_t    lim_out;
   } cts_state_t;

endpackage

`default_nettype wire

// ===== src/cts_vec_mag.sv
/*
   Phasor magnitude estimate: larger component plus half the smaller one.
   Assumes two's complement real and imaginary parts; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module cts_vec_mag
#(
   parameter int W = 16
)
(
   // Phasor in
   input  wire logic signed [W-1:0] re,
   input  wire logic signed [W-1:0] im,
   // Magnitude estimate, never above 1.5 times the larger part
   output logic             [W-1:0] mag
);

   // Absolute value; the most negative input still fits unsigned
   function automatic logic [W-1:0] abs_of(input logic signed [W-1:0] x);
      abs_of = x[W-1] ? W'(-x) : W'(x);
   endfunction

   logic [W-1:0] a_re;
   logic [W-1:0] a_im;

   // Larger plus half the smaller
   always_comb
   begin
      a_re = abs_of(re);
      a_im = abs_of(im);
      if (a_re >= a_im)
      begin
         mag = a_re + (a_im >> 1);
      end
      else
      begin
         mag = a_im + (a_re >> 1);
      end
   end

endmodule

`default_nettype wire

// ===== src/cts_supervision.sv
/*
   Current-transformer circuit supervision: compares the residual built from
   three phase phasors with the separately measured earth phasor and raises
   an alarm when their corrected sum reaches a current-dependent limit.
   Assumes phasor samples synchronous to MCLK, one strobe per sample, and
   rated transformer values and settings held steady while enabled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cts_cfg.svh"

module cts_supervision
(
   // Clock, reset, clock enable
   input  wire logic                     MCLK,
   input  wire logic                     RST,
   input  wire logic                     CE,
   // Function enable and settings
   input  wire logic                     SUP_EN,
   input  wire logic [`CTS_CUR_W-1:0]    BASE_DEVIATION_SETTING,
   input  wire logic [`CTS_SLOPE_W-1:0]  DYNAMIC_SLOPE_FACTOR,
   // Rated transformer values
   input  wire logic [`CTS_RATED_W-1:0]  PHASE_PRI_RATED,
   input  wire logic [`CTS_RATED_W-1:0]  PHASE_SEC_RATED,
   input  wire logic [`CTS_RATED_W-1:0]  EARTH_PRI_RATED,
   input  wire logic [`CTS_RATED_W-1:0]  EARTH_SEC_RATED,
   // Phasor samples, secondary units
   input  wire logic                     SAMPLE_VALID,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_A_CURRENT_RE,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_A_CURRENT_IM,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_B_CURRENT_RE,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_B_CURRENT_IM,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_C_CURRENT_RE,
   input  wire logic signed [`CTS_CUR_W-1:0] PHASE_C_CURRENT_IM,
   input  wire logic signed [`CTS_CUR_W-1:0] MEASURED_EARTH_CURRENT_RE,
   input  wire logic signed [`CTS_CUR_W-1:0] MEASURED_EARTH_CURRENT_IM,
   // Alarm and observation outputs
   output logic                          CTS_ALARM,
   output logic                          CTS_ALARM_EVENT,
   output logic [`CTS_RES_W-1:0]         RESIDUAL_MAGNITUDE,
   output logic [`CTS_LIM_W-1:0]         BASE_DEVIATION_LIMIT
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   cts_pkg::cts_state_t st_ff;
   cts_pkg::cts_state_t nxt_st;

   cts_pkg::mag_t  mag_a;
   cts_pkg::mag_t  mag_b;
   cts_pkg::mag_t  mag_c;

   // Residual magnitude estimate on the full scaled width
   cts_pkg::resmag_t res_mag_out;

   // Residual passed on at the full scaled width, no rounding
   logic signed [`CTS_RES_W-1:0] res_re_w;
   logic signed [`CTS_RES_W-1:0] res_im_w;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Largest of three magnitudes
   function automatic cts_pkg::mag_t max3(input cts_pkg::mag_t a,
                                          input cts_pkg::mag_t b,
                                          input cts_pkg::mag_t c);
      cts_pkg::mag_t m;
      m = (a > b) ? a : b;
      max3 = (m > c) ? m : c;
   endfunction

   // Product of two rated values
   function automatic cts_pkg::prod_t rated_mul(input cts_pkg::rated_t x,
                                                input cts_pkg::rated_t y);
      rated_mul = cts_pkg::prod_t'(x) * cts_pkg::prod_t'(y);
   endfunction

   // Signed sample times an unsigned rated product
   function automatic cts_pkg::res_t scale(input logic signed [`CTS_CUR_W+1:0] s,
                                           input cts_pkg::prod_t k);
      logic signed [`CTS_RES_W-1:0] se;
      logic signed [`CTS_RES_W-1:0] ke;
      se = `CTS_RES_W'(s);
      ke = `CTS_RES_W'({1'b0, k});
      scale = `CTS_RES_W'(se * ke);
   endfunction

   // Sum of three phase components, widened so it cannot wrap
   function automatic logic signed [`CTS_CUR_W+1:0] sum3(
      input logic signed [`CTS_CUR_W-1:0] a,
      input logic signed [`CTS_CUR_W-1:0] b,
      input logic signed [`CTS_CUR_W-1:0] c);
      sum3 = (`CTS_CUR_W+2)'(a) + (`CTS_CUR_W+2)'(b) + (`CTS_CUR_W+2)'(c);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Magnitude estimators

   // Phase magnitudes feed the largest-current search
   cts_vec_mag #(.W(`CTS_CUR_W)) u_mag_a
   (
      .re  (PHASE_A_CURRENT_RE),
      .im  (PHASE_A_CURRENT_IM),
      .mag (mag_a)
   );

   cts_vec_mag #(.W(`CTS_CUR_W)) u_mag_b
   (
      .re  (PHASE_B_CURRENT_RE),
      .im  (PHASE_B_CURRENT_IM),
      .mag (mag_b)
   );

   cts_vec_mag #(.W(`CTS_CUR_W)) u_mag_c
   (
      .re  (PHASE_C_CURRENT_RE),
      .im  (PHASE_C_CURRENT_IM),
      .mag (mag_c)
   );

   // Residual magnitude on the full scaled width
   cts_vec_mag #(.W(`CTS_RES_W)) u_mag_res
   (
      .re  (res_re_w),
      .im  (res_im_w),
      .mag (res_mag_out)
   );

   // Stage-one residual feeds the magnitude estimator
   assign res_re_w = st_ff.res_re;
   assign res_im_w = st_ff.res_im;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Three-stage pipeline: residual and limit inputs, magnitudes, decision
   always_comb
   begin
      cts_pkg::prod_t earth_scale;
      cts_pkg::res_t  ph_re;
      cts_pkg::res_t  ph_im;
      cts_pkg::res_t  ea_re;
      cts_pkg::res_t  ea_im;
      logic [`CTS_CUR_W+`CTS_SLOPE_W-1:0] slope_prod;
      logic [`CTS_CUR_W:0]                lim_sec;
      logic [`CTS_LIM_W-1:0]              lim_scaled;
      logic                               fault;

      nxt_st      = st_ff;
      earth_scale = cts_pkg::prod_t'(0);
      ph_re       = cts_pkg::res_t'(0);
      ph_im       = cts_pkg::res_t'(0);
      ea_re       = cts_pkg::res_t'(0);
      ea_im       = cts_pkg::res_t'(0);
      slope_prod  = '0;
      lim_sec     = '0;
      lim_scaled  = '0;
      fault       = 1'b0;

      // Stage 1: both sides brought to a common primary scale.
      // Phase side times phase-primary and earth-secondary, earth side times
      // earth-primary and phase-secondary, so no divider is needed.
      nxt_st.phase_scale = rated_mul(PHASE_PRI_RATED, EARTH_SEC_RATED);
      earth_scale        = rated_mul(EARTH_PRI_RATED, PHASE_SEC_RATED);
      ph_re = scale(sum3(PHASE_A_CURRENT_RE, PHASE_B_CURRENT_RE,
                         PHASE_C_CURRENT_RE), nxt_st.phase_scale);
      ph_im = scale(sum3(PHASE_A_CURRENT_IM, PHASE_B_CURRENT_IM,
                         PHASE_C_CURRENT_IM), nxt_st.phase_scale);
      ea_re = scale((`CTS_CUR_W+2)'(MEASURED_EARTH_CURRENT_RE), earth_scale);
      ea_im = scale((`CTS_CUR_W+2)'(MEASURED_EARTH_CURRENT_IM), earth_scale);
      nxt_st.res_re = ph_re + ea_re;
      nxt_st.res_im = ph_im + ea_im;
      nxt_st.imax   = max3(mag_a, mag_b, mag_c);
      nxt_st.v1     = SAMPLE_VALID & SUP_EN;

      // Stage 2: residual magnitude and the current-dependent limit
      slope_prod = (`CTS_CUR_W+`CTS_SLOPE_W)'(st_ff.imax) *
                   (`CTS_CUR_W+`CTS_SLOPE_W)'(DYNAMIC_SLOPE_FACTOR);
      lim_sec = (`CTS_CUR_W+1)'(BASE_DEVIATION_SETTING) +
                (`CTS_CUR_W+1)'(slope_prod >> `CTS_SLOPE_FRAC);
      lim_scaled = `CTS_LIM_W'(`CTS_LIM_W'(lim_sec) *
                               `CTS_LIM_W'(st_ff.phase_scale));
      nxt_st.res_mag = res_mag_out;
      nxt_st.lim     = lim_scaled;
      nxt_st.v2      = st_ff.v1 & SUP_EN;

      // Stage 3: decision; greater-or-equal counts as a failure
      fault = st_ff.res_mag >= cts_pkg::resmag_t'(st_ff.lim);
      nxt_st.alarm_evt = 1'b0;
      if (!SUP_EN)
      begin
         // Disabled: nothing evaluated, alarm forced low
         nxt_st.alarm = `CTS_ALARM_RST;
         nxt_st.v1    = `CTS_VALID_RST;
         nxt_st.v2    = `CTS_VALID_RST;
      end
      else if (st_ff.v2)
      begin
         // Alarm follows each evaluated sample
         nxt_st.alarm     = fault;
         nxt_st.alarm_evt = fault & ~st_ff.alarm;
         nxt_st.mag_out   = st_ff.res_mag;
         nxt_st.lim_out   = st_ff.lim;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   // Synchronous reset, clock enable freezes everything
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         st_ff <= '0;
      end
      else if (CE)
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // All outputs come straight from the state register
   assign CTS_ALARM            = st_ff.alarm;
   assign CTS_ALARM_EVENT      = st_ff.alarm_evt;
   assign RESIDUAL_MAGNITUDE   = st_ff.mag_out;
   assign BASE_DEVIATION_LIMIT = st_ff.lim_out;

endmodule

`default_nettype wire

// ===== testbench/cts_chk_properties.sv
/*
   Port checker for the circuit supervision block.
   Assumes binding to cts_supervision with CE high while samples fly.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_chk
(
   // Clock, reset, enables
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        SUP_EN,
   // Settings and sample strobe
   input wire logic [15:0] BASE_DEVIATION_SETTING,
   input wire logic [7:0]  DYNAMIC_SLOPE_FACTOR,
   input wire logic [11:0] PHASE_PRI_RATED,
   input wire logic [11:0] EARTH_SEC_RATED,
   input wire logic        SAMPLE_VALID,
   // Results
   input wire logic        CTS_ALARM,
   input wire logic        CTS_ALARM_EVENT,
   input wire logic [42:0] RESIDUAL_MAGNITUDE,
   input wire logic [40:0] BASE_DEVIATION_LIMIT
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   logic [40:0] floor_w;
   // Lowest limit: base deviation scaled into residual units
   assign floor_w = 41'(BASE_DEVIATION_SETTING) * 41'(PHASE_PRI_RATED) * 41'(EARTH_SEC_RATED);
   ////////////////////////////////////////////////////////////////////////
   // Sample taken, then two enabled edges until the result lands
   sequence s_flight;
      SAMPLE_VALID && SUP_EN && CE ##1 (SUP_EN && CE) [*2];
   endsequence
   sequence s_quiet;
      (!SAMPLE_VALID && SUP_EN) [*3] ##1 SUP_EN;
   endsequence
   property p_cmp; s_flight |=> CTS_ALARM == (RESIDUAL_MAGNITUDE >= BASE_DEVIATION_LIMIT); endproperty
   property p_floor; s_flight |=> BASE_DEVIATION_LIMIT >= floor_w; endproperty
   property p_slope0; s_flight ##0 DYNAMIC_SLOPE_FACTOR == 8'h00 |=> BASE_DEVIATION_LIMIT == floor_w; endproperty
   property p_hold; s_quiet |=> $stable(CTS_ALARM); endproperty
   property p_off; (!SUP_EN && CE) |=> !CTS_ALARM; endproperty
   property p_reen; (!SUP_EN && CE) ##1 SUP_EN [*2] |=> !CTS_ALARM; endproperty
   property p_rise; $rose(CTS_ALARM) |-> CTS_ALARM_EVENT; endproperty
   property p_pulse; CTS_ALARM_EVENT && CE |=> !CTS_ALARM_EVENT; endproperty
   property p_cause; CTS_ALARM |-> $past(SUP_EN) || !$past(CE); endproperty
   a_cmp: assert property (p_cmp)
      else $error("alarm disagrees with magnitude and limit");
   a_floor: assert property (p_floor)
      else $error("limit below base deviation");
   a_slope0: assert property (p_slope0)
      else $error("limit grows without slope");
   a_hold: assert property (p_hold)
      else $error("alarm moved without a sample");
   a_off: assert property (p_off)
      else $error("alarm kept while disabled");
   a_reen: assert property (p_reen)
      else $error("dropped sample raised alarm");
   a_rise: assert property (p_rise)
      else $error("no event on alarm rise");
   a_pulse: assert property (p_pulse)
      else $error("event longer than one cycle");
   a_cause: assert property (p_cause)
      else $error("alarm without supervision");
endmodule
bind cts_supervision cts_chk chk (.MCLK, .RST, .CE, .SUP_EN, .BASE_DEVIATION_SETTING,
   .DYNAMIC_SLOPE_FACTOR, .PHASE_PRI_RATED, .EARTH_SEC_RATED, .SAMPLE_VALID, .CTS_ALARM,
   .CTS_ALARM_EVENT, .RESIDUAL_MAGNITUDE, .BASE_DEVIATION_LIMIT);
`default_nettype wire

// ===== testbench/cts_feed.sv
/*
   Phasor source standing in for the digitised current inputs.
   Assumes the bench calls put and rest in turn.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_feed
(
   // Clock
   input wire logic      clk,
   // Strobe and phasors
   output logic          valid,
   output var cts_pkg::cur_t ph [8]
);
   // Idle at start
   initial
   begin
      valid = 1'b0;
      ph = '{default: 16'h0000};
   end
   // One whole set: three phases and the earth input
   task automatic put(input cts_pkg::cur_t v [8]);
      @(posedge clk);
      #1;
      valid = 1'b1;
      ph = v;
   endtask
   // Strobe off, stale data flipped so it is never trusted
   task automatic rest();
      @(posedge clk);
      #1;
      valid = 1'b0;
      foreach (ph[i]) ph[i] = ~ph[i];
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/*
   Self-checking bench for cts_supervision against an integer model.
   Assumes cts_feed drives the phasors and cts_chk is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cts_cfg.svh"
module tb_top;
   typedef struct {int due; longint mg; longint lm;} exp_t;
   logic          mclk = 1'b0, rst = 1'b1, sup_en = 1'b0, ce = 1'b1, valid, alarm, evt;
   logic          last = 1'b0, want;
   logic [42:0]   rmag;
   logic [40:0]   lim;
   logic [15:0]   lfsr = 16'h0056;
   cts_pkg::cur_t ph [8], v [8], bal [8];
   int            base = 100, slope = 0, rt [4] = '{1, 1, 1, 1};
   int            cyc = 0, fail_count = 0, num_checks = 0;
   exp_t          q [$];
   always #5 mclk = ~mclk;
   cts_feed feed (.clk(mclk), .valid(valid), .ph(ph));
   cts_supervision DUT (.MCLK(mclk), .RST(rst), .CE(ce), .SUP_EN(sup_en),
      .BASE_DEVIATION_SETTING(16'(base)), .DYNAMIC_SLOPE_FACTOR(8'(slope)),
      .PHASE_PRI_RATED(12'(rt[0])), .PHASE_SEC_RATED(12'(rt[1])),
      .EARTH_PRI_RATED(12'(rt[2])), .EARTH_SEC_RATED(12'(rt[3])), .SAMPLE_VALID(valid),
      .PHASE_A_CURRENT_RE(ph[0]), .PHASE_A_CURRENT_IM(ph[1]), .PHASE_B_CURRENT_RE(ph[2]),
      .PHASE_B_CURRENT_IM(ph[3]), .PHASE_C_CURRENT_RE(ph[4]), .PHASE_C_CURRENT_IM(ph[5]),
      .MEASURED_EARTH_CURRENT_RE(ph[6]), .MEASURED_EARTH_CURRENT_IM(ph[7]),
      .CTS_ALARM(alarm), .CTS_ALARM_EVENT(evt), .RESIDUAL_MAGNITUDE(rmag),
      .BASE_DEVIATION_LIMIT(lim));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   // Magnitude estimate: larger part plus half the smaller
   function automatic longint est(longint a, longint b);
      a = a < 0 ? -a : a;
      b = b < 0 ? -b : b;
      return a > b ? a + (b >>> 1) : b + (a >>> 1);
   endfunction
   task automatic bad(string m);
      fail_count++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk(logic got, logic want, string m);
      num_checks++;
      if (got !== want) bad(m);
   endtask
   // Present a sample and queue what the model expects three edges on
   task automatic send(input cts_pkg::cur_t x [8]);
      longint s [8];
      longint re, im, mx;
      exp_t e;
      foreach (x[i]) s[i] = x[i];
      re = (s[0] + s[2] + s[4]) * rt[0] * rt[3] + s[6] * rt[2] * rt[1];
      im = (s[1] + s[3] + s[5]) * rt[0] * rt[3] + s[7] * rt[2] * rt[1];
      mx = est(s[0], s[1]);
      for (int i = 2; i < 6; i += 2) if (est(s[i], s[i+1]) > mx) mx = est(s[i], s[i+1]);
      e.mg = est(re, im);
      e.lm = (base + ((mx * slope) >>> 8)) * rt[0] * rt[3];
      feed.put(x);
      // Strobe raised after edge cyc, taken at the next, result two edges on
      e.due = cyc + `CTS_LATENCY;
      q.push_back(e);
   endtask
   task automatic summarize();
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare each result in the cycle it lands
   always @(posedge mclk)
   begin
      cyc++;
      #2;
      if (q.size() > 0 && q[0].due == cyc)
      begin
         want = q[0].mg >= q[0].lm;
         num_checks++;
         if (rmag !== 43'(q[0].mg) || lim !== 41'(q[0].lm))
            bad("result");
         num_checks++;
         if (alarm !== want || evt !== (want && !last))
            bad("alarm");
         last = want;
         void'(q.pop_front());
      end
   end
   initial
   begin
      repeat (3000) @(posedge mclk);
      fail_count++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      bal = '{16'h03E8, 16'h0000, 16'hFE0C, 16'hFC9E, 16'hFE0C, 16'h0362, 16'h0000, 16'h0000};
      repeat (12) @(posedge mclk);
      #1;
      rst = 1'b0;
      sup_en = 1'b1;
      // Balanced feed, earth at and under the limit, one phase lost
      send(bal);
      v = bal;
      v[6] = 16'h0064;
      send(v);
      v[6] = 16'h0063;
      send(v);
      v = bal;
      v[0] = 16'h0000;
      send(v);
      feed.rest();
      repeat (4) @(posedge mclk);
      // Clock enable low freezes the raised alarm through a disable
      #1;
      ce = 1'b0;
      sup_en = 1'b0;
      last = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(alarm, 1'b1, "alarm not frozen");
      ce = 1'b1;
      @(posedge mclk);
      #2;
      chk(alarm, 1'b0, "alarm kept");
      // Samples while disabled or cut off in flight are dropped
      feed.put(v);
      feed.rest();
      sup_en = 1'b1;
      feed.put(v);
      @(posedge mclk);
      #1;
      sup_en = 1'b0;
      feed.rest();
      repeat (4) @(posedge mclk);
      #1;
      chk(alarm, 1'b0, "dropped sample");
      sup_en = 1'b1;
      // Random ratings, settings and back-to-back phasors
      repeat (8)
      begin
         repeat (3) @(posedge mclk);
         #1;
         foreach (rt[i]) rt[i] = int'(rnd() & 16'h0FFF) | 1;
         base = int'(rnd());
         slope = int'(rnd() & 16'h00FF);
         repeat (3) @(posedge mclk);
         repeat (6)
         begin
            foreach (v[i]) v[i] = rnd();
            send(v);
         end
         feed.rest();
      end
      repeat (6) @(posedge mclk);
      if (q.size() != 0) bad("missing result");
      summarize();
   end
endmodule
`default_nettype wire
